// ### test/codec_ctrl_properties.sv
`timescale 1ns/1ps
module codec_ctrl_properties
    import codec_ctrl_pkg::*;
#(
    parameter int MCLK_LOSS_LIMIT = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic master_clock,
    input wire logic cfg_we,
    input wire logic [PWR_WIDTH-1:0] cfg_power,
    input wire logic [TXG_WIDTH-1:0] cfg_tx_gain,
    input wire logic pcm_serial_out_oe,
    input wire logic [PWR_WIDTH-1:0] power_register,
    input wire logic [TXG_WIDTH-1:0] transmit_gain_register,
    input wire logic differential_earpiece_amp,
    input wire logic single_ended_earpiece_amp,
    input wire logic microphone_mute_select,
    input wire logic powered_up,
    input wire logic mclk_lost,
    input wire logic tx_gain_mode_bit,
    input wire logic [4:0] tx_mic2_gain_db,
    input wire logic [3:0] tx_pga_atten_db
);
    // ************************************************************
    // power and gain checks
    // ************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic mclk_q;
    logic [15:0] still_q;
    wire [7:0] txg = transmit_gain_register;
    wire [3:0] atten = (txg[2:0] > TXG_STEP_MAX) ? 4'ha : {txg[2:0], 1'b0};
    wire [4:0] mic2 = txg[TXG_MODE_BIT] ? 5'h00 : MIC2_GAIN_DB;
    wire ear = power_register[PWR_EAR_SEL_BIT];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mclk_q <= 1'b0;
            still_q <= 16'h0000;
        end else begin
            mclk_q <= master_clock;
            if (mclk_q != master_clock) begin
                still_q <= 16'h0000;
            end else if (still_q != 16'hffff) begin
                still_q <= still_q + 16'h0001;
            end
        end
    end
    property p_cfg_load;
        cfg_we |=> power_register == $past(cfg_power)
            && transmit_gain_register == $past(cfg_tx_gain);
    endproperty
    a_cfg_load: assert property (p_cfg_load)
        else $error("config not stored");
    property p_ear_select;
        powered_up && $past(powered_up) && $stable(power_register)
            |-> differential_earpiece_amp == ear
            && single_ended_earpiece_amp == !ear;
    endproperty
    a_ear_select: assert property (p_ear_select)
        else $error("wrong earpiece amplifier");
    property p_power_off;
        $fell(power_register[PWR_ON_BIT]) |-> ##[0:500] !powered_up;
    endproperty
    a_power_off: assert property (p_power_off)
        else $error("power bit clear ignored");
    property p_force_off;
        txg[TXG_FORCE_PD_BIT] |-> ##[0:500] !powered_up;
    endproperty
    a_force_off: assert property (p_force_off)
        else $error("forced power-down ignored");
    property p_clock_loss;
        still_q > MCLK_LOSS_LIMIT + 6 && !txg[TXG_FORCE_PD_BIT]
            |-> mclk_lost && !pcm_serial_out_oe && !powered_up;
    endproperty
    a_clock_loss: assert property (p_clock_loss)
        else $error("clock loss not handled");
    property p_mute;
        $stable(power_register)
            |-> microphone_mute_select == power_register[PWR_MIC_MUTE_BIT];
    endproperty
    a_mute: assert property (p_mute)
        else $error("mute select wrong");
    property p_gain_mode;
        $stable(txg) |-> tx_gain_mode_bit == txg[TXG_MODE_BIT]
            && tx_mic2_gain_db == mic2;
    endproperty
    a_gain_mode: assert property (p_gain_mode)
        else $error("gain mode decode wrong");
    property p_gain_step;
        $stable(txg) |-> tx_pga_atten_db == atten;
    endproperty
    a_gain_step: assert property (p_gain_step)
        else $error("gain step decode wrong");
    c_diff_on: cover property (powered_up && differential_earpiece_amp);
    c_lost: cover property (mclk_lost);
    c_drain: cover property ($fell(power_register[PWR_ON_BIT])
        && pcm_serial_out_oe);
endmodule : codec_ctrl_properties

bind codec_power_and_tx_gain_control codec_ctrl_properties #(
    .MCLK_LOSS_LIMIT(MCLK_LOSS_LIMIT)
) chk_u (.*);

// ### test/pcm_frame_master.sv
`timescale 1ns/1ps
module pcm_frame_master
    import codec_ctrl_pkg::*;
(
    input wire logic run,
    input wire logic [15:0] rx_word,
    input wire logic [4:0] rx_len,
    input wire logic pcm_serial_out,
    input wire logic pcm_serial_out_oe,
    output logic pcm_bit_clock,
    output logic pcm_frame_sync,
    output logic pcm_serial_in,
    output logic [15:0] cap_word,
    output logic [8:0] cap_bits,
    output int frames
);
    // ************************************************************
    // one frame per rise of run, bit clock still between frames
    // ************************************************************
    initial begin
        {pcm_bit_clock, pcm_frame_sync, pcm_serial_in} = 3'h0;
        frames = 0;
        forever begin
            @(posedge run);
            cap_word = 16'h0000;
            cap_bits = 9'h000;
            for (int i = 0; i < BITS_PER_FRAME; i++) begin
                pcm_bit_clock = 1'b1;
                pcm_frame_sync = (i == 0);
                pcm_serial_in = (i >= 1 && i <= rx_len) ?
                    rx_word[rx_len - i] : i[0];
                #62.5;
                pcm_bit_clock = 1'b0;
                if (pcm_serial_out_oe === 1'b1) begin
                    cap_word = {cap_word[14:0], pcm_serial_out};
                    cap_bits++;
                end
                #62.5;
            end
            frames++;
        end
    end
endmodule : pcm_frame_master

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import codec_ctrl_pkg::*;
    localparam int LOSS = 20;
    logic clk, rst_n, master_clock, mclk_run, cfg_we, sample_valid, run;
    logic sample_ready, pcm_bit_clock, pcm_frame_sync, pcm_serial_in;
    logic pcm_serial_out, pcm_serial_out_oe, rx_sample_valid;
    logic differential_earpiece_amp, single_ended_earpiece_amp;
    logic microphone_mute_select, powered_up, mclk_lost, tx_gain_mode_bit;
    logic [7:0] cfg_power, cfg_tx_gain, power_register, transmit_gain_register;
    logic [1:0] cfg_format, format_q;
    logic [4:0] tx_mic2_gain_db, rx_len;
    logic [3:0] tx_pga_atten_db;
    logic [8:0] cap_bits;
    logic [15:0] sample_data, rx_sample, rx_word, rx_got, cap_word, smp;
    logic [15:0] q[FIFO_DEPTH];
    logic [31:0] r;
    int seed, err_total, checks_done, frames, n;
    wire [15:0] gain_seen = {6'h00, tx_gain_mode_bit, tx_mic2_gain_db,
        tx_pga_atten_db};
    wire [1:0] ears = {differential_earpiece_amp, single_ended_earpiece_amp};
    codec_power_and_tx_gain_control #(.MCLK_LOSS_LIMIT(LOSS)) dut_u (.*);
    pcm_frame_master far_u (.*);
    // ************************************************************
    // clocks, helpers and sequence
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        master_clock = 1'b0;
        forever #40 master_clock = mclk_run ? ~master_clock : master_clock;
    end
    always @(posedge clk) begin
        if (rx_sample_valid) rx_got <= rx_sample;
    end
    initial begin
        #400000;
        err_total++;
        report_and_stop();
    end
    function automatic logic [15:0] exp_gain(logic [3:0] c);
        logic [3:0] a;
        a = (c[2:0] > 3'h5) ? 4'ha : {c[2:0], 1'b0};
        return {6'h00, c[3], c[3] ? 5'h00 : 5'h0c, a};
    endfunction : exp_gain
    function automatic logic [15:0] mask(int w);
        return 16'((32'h0000_0001 << w) - 1);
    endfunction : mask
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic cfg(logic [7:0] pwr, logic [7:0] txg, logic [1:0] fmt);
        @(posedge clk);
        #1;
        {cfg_we, cfg_power, cfg_tx_gain, cfg_format} = {1'b1, pwr, txg, fmt};
        @(posedge clk);
        #1;
        cfg_we = 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask : cfg
    task automatic push(logic [15:0] v);
        int k;
        k = 0;
        sample_data = v;
        sample_valid = 1'b1;
        while (sample_ready !== 1'b1 && k < 50) begin
            @(posedge clk);
            #1;
            k++;
        end
        @(posedge clk);
        #1;
    endtask : push
    task automatic frame();
        int f, k;
        f = frames;
        k = 0;
        run = 1'b1;
        while (frames == f && k < 9000) begin
            @(posedge clk);
            k++;
        end
        #1;
        run = 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask : frame
    task automatic tx_check(logic [15:0] v, int w);
        check("tx bits", 16'(cap_bits), 16'(w));
        check("tx word", cap_word, v & mask(w));
        check("rx word", rx_got, rx_word & mask(w));
    endtask : tx_check
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        seed = 32'h30c8;
        {rst_n, cfg_we, sample_valid, run, mclk_run} = 5'h01;
        {cfg_power, cfg_tx_gain, cfg_format, sample_data, rx_word} = '0;
        rx_len = 5'h0f;
        repeat (RESET_MIN_CYCLES) @(posedge clk);
        #1;
        rst_n = 1'b1;
        check("pwr reg", 16'(power_register), 16'(PWR_RESET));
        check("txg reg", 16'(transmit_gain_register), 16'(TXG_RESET));
        check("format", 16'(format_q), 16'(FMT_RESET));
        check("gain", gain_seen, exp_gain(4'h8));
        $display("test reset finished");
        for (int c = 0; c < 16; c++) begin
            r = $random(seed);
            cfg(8'h00, {1'b0, r[6:4], 4'(c)}, FMT_LINEAR);
            check("txg", 16'(transmit_gain_register), 16'(cfg_tx_gain));
            check("gain", gain_seen, exp_gain(4'(c)));
        end
        $display("test gain codes finished");
        for (int s = 0; s < 2; s++) begin
            r = $random(seed);
            cfg({1'b0, r[0], 4'h0, 1'(s), 1'b1}, TXG_RESET, FMT_LINEAR);
            check("ears", 16'(ears), 16'(s ? 2 : 1));
            check("mute", 16'(microphone_mute_select), 16'(r[0]));
            cfg(8'h00, TXG_RESET, FMT_LINEAR);
            check("on", 16'(powered_up), 16'h0000);
        end
        $display("test power select finished");
        cfg(8'h01, TXG_RESET, FMT_LINEAR);
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            q[i] = 16'($random(seed));
            push(q[i]);
        end
        sample_valid = 1'b0;
        repeat (3) @(posedge clk);
        check("fifo full", 16'(sample_ready), 16'h0000);
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            rx_word = 16'($random(seed));
            frame();
            tx_check(q[i], LINEAR_BITS);
        end
        check("fifo drained", 16'(sample_ready), 16'h0001);
        rx_len = 5'h08;
        for (int k = 1; k < 3; k++) begin
            cfg(8'h01, TXG_RESET, 2'(k));
            smp = 16'($random(seed));
            push(smp);
            sample_valid = 1'b0;
            rx_word = 16'($random(seed));
            frame();
            tx_check(smp, COMPANDED_BITS);
        end
        rx_word = 16'($random(seed));
        frame();
        tx_check(16'h0000, COMPANDED_BITS);
        $display("test stream finished");
        smp = 16'($random(seed));
        push(smp);
        sample_valid = 1'b0;
        run = 1'b1;
        n = 0;
        while (pcm_serial_out_oe !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        cfg(8'h00, TXG_RESET, FMT_ALAW);
        frame();
        check("drain bits", 16'(cap_bits), 16'(COMPANDED_BITS));
        check("drain word", cap_word, smp & 16'h00ff);
        check("on", 16'(powered_up), 16'h0000);
        cfg(8'h01, TXG_RESET, FMT_ALAW);
        check("on", 16'(powered_up), 16'h0001);
        cfg(8'h01, 8'h88, FMT_ALAW);
        check("on", 16'(powered_up), 16'h0000);
        cfg(8'h01, TXG_RESET, FMT_ALAW);
        mclk_run = 1'b0;
        repeat (LOSS + 10) @(posedge clk);
        #1;
        check("lost", 16'(mclk_lost), 16'h0001);
        check("on", 16'(powered_up), 16'h0000);
        check("oe", 16'(pcm_serial_out_oe), 16'h0000);
        $display("test power down finished");
        report_and_stop();
    end
endmodule : tb_top

// ### verilog/codec_ctrl_pkg.sv
package codec_ctrl_pkg;
    // ****************************************************************
    // power control register fields
    // ****************************************************************
    localparam int PWR_WIDTH = 8;
    localparam int PWR_ON_BIT = 0;
    localparam int PWR_EAR_SEL_BIT = 1;
    localparam int PWR_MIC_MUTE_BIT = 6;
    localparam logic [7:0] PWR_RESET = 8'h00;
    // ****************************************************************
    // transmit gain / sidetone register fields
    // ****************************************************************
    localparam int TXG_WIDTH = 8;
    localparam int TXG_FORCE_PD_BIT = 7;
    localparam int TXG_MODE_BIT = 3;
    localparam logic [7:0] TXG_RESET = 8'h08;
    localparam logic [2:0] TXG_STEP_MAX = 3'h5;
    localparam logic [4:0] MIC2_GAIN_DB = 5'h0c;
    // ****************************************************************
    // format and framing
    // ****************************************************************
    localparam logic [1:0] FMT_LINEAR = 2'h0;
    localparam logic [1:0] FMT_MULAW = 2'h1;
    localparam logic [1:0] FMT_ALAW = 2'h2;
    localparam logic [1:0] FMT_RESET = 2'h0;
    localparam int LINEAR_BITS = 15;
    localparam int COMPANDED_BITS = 8;
    localparam int SAMPLE_WIDTH = 16;
    localparam int BITS_PER_FRAME = 256;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RESET_MIN_NS = 500;
    localparam int RESET_MIN_CYCLES =
        (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MCLK_LOSS_NS = 2000;
    localparam int MCLK_LOSS_CYCLES = MCLK_LOSS_NS * 1000 / CLK_PERIOD_PS;
    localparam int FIFO_DEPTH = 4;

    typedef struct packed {
        logic on;
        logic diff_ear;
        logic single_ear;
        logic mic_mute;
    } power_state_t;

    typedef struct packed {
        logic extended;
        logic [4:0] mic2_gain_db;
        logic [3:0] pga_atten_db;
    } tx_gain_t;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_ON = 2'b01,
        ST_DRAIN = 2'b11
    } pwr_state_t;
endpackage : codec_ctrl_pkg

// ### verilog/codec_power_and_tx_gain_control.sv
`timescale 1ns/1ps
module codec_power_and_tx_gain_control
    import codec_ctrl_pkg::*;
#(
    parameter int MCLK_LOSS_LIMIT = MCLK_LOSS_CYCLES,
    parameter int FIFO_WORDS = FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic master_clock,
    input wire logic cfg_we,
    input wire logic [PWR_WIDTH-1:0] cfg_power,
    input wire logic [TXG_WIDTH-1:0] cfg_tx_gain,
    input wire logic [1:0] cfg_format,
    input wire logic sample_valid,
    output logic sample_ready,
    input wire logic [SAMPLE_WIDTH-1:0] sample_data,
    input wire logic pcm_bit_clock,
    input wire logic pcm_frame_sync,
    input wire logic pcm_serial_in,
    output logic pcm_serial_out,
    output logic pcm_serial_out_oe,
    output logic [SAMPLE_WIDTH-1:0] rx_sample,
    output logic rx_sample_valid,
    output logic [PWR_WIDTH-1:0] power_register,
    output logic [TXG_WIDTH-1:0] transmit_gain_register,
    output logic [1:0] format_q,
    output logic differential_earpiece_amp,
    output logic single_ended_earpiece_amp,
    output logic microphone_mute_select,
    output logic powered_up,
    output logic mclk_lost,
    output logic tx_gain_mode_bit,
    output logic [4:0] tx_mic2_gain_db,
    output logic [3:0] tx_pga_atten_db
);
    // ****************************************************************
    // synchronisers
    // ****************************************************************
    logic [1:0] bclk_s_q;
    logic [1:0] fs_s_q;
    logic [1:0] din_s_q;
    logic [1:0] mclk_s_q;
    logic bclk_d1_q;
    logic mclk_d1_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bclk_s_q <= '0;
            fs_s_q <= '0;
            din_s_q <= '0;
            mclk_s_q <= '0;
            bclk_d1_q <= 1'b0;
            mclk_d1_q <= 1'b0;
        end else begin
            bclk_s_q <= {bclk_s_q[0], pcm_bit_clock};
            fs_s_q <= {fs_s_q[0], pcm_frame_sync};
            din_s_q <= {din_s_q[0], pcm_serial_in};
            mclk_s_q <= {mclk_s_q[0], master_clock};
            bclk_d1_q <= bclk_s_q[1];
            mclk_d1_q <= mclk_s_q[1];
        end
    end
    wire bclk_rise = bclk_s_q[1] && !bclk_d1_q;
    wire bclk_fall = !bclk_s_q[1] && bclk_d1_q;
    wire mclk_edge = mclk_s_q[1] != mclk_d1_q;

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    logic [PWR_WIDTH-1:0] pwr_q;
    logic [TXG_WIDTH-1:0] txg_q;
    logic [1:0] fmt_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_q <= PWR_RESET;
            txg_q <= TXG_RESET;
            fmt_q <= FMT_RESET;
        end else if (cfg_we) begin
            pwr_q <= cfg_power;
            txg_q <= cfg_tx_gain;
            fmt_q <= cfg_format;
        end
    end

    // ****************************************************************
    // master clock loss detection
    // ****************************************************************
    localparam int LW = $clog2(MCLK_LOSS_LIMIT + 1);
    logic [LW-1:0] idle_cnt_q;
    logic lost_q;
    wire loss_hit = idle_cnt_q == LW'(MCLK_LOSS_LIMIT);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt_q <= '0;
            lost_q <= 1'b0;
        end else if (mclk_edge) begin
            idle_cnt_q <= '0;
            lost_q <= 1'b0;
        end else if (!loss_hit) begin
            idle_cnt_q <= idle_cnt_q + 1'b1;
        end else begin
            lost_q <= 1'b1;
        end
    end

    // ****************************************************************
    // transmit gain decode
    // ****************************************************************
    function automatic tx_gain_t gain_decode(input logic [3:0] code);
        logic [2:0] step;
        step = (code[2:0] > TXG_STEP_MAX) ? TXG_STEP_MAX : code[2:0];
        gain_decode.extended = !code[3];
        gain_decode.mic2_gain_db = code[3] ? 5'h0 : MIC2_GAIN_DB;
        gain_decode.pga_atten_db = {step, 1'b0};
    endfunction : gain_decode
    wire tx_gain_t gain_w = gain_decode(txg_q[TXG_MODE_BIT:0]);

    // ****************************************************************
    // power state machine
    // ****************************************************************
    pwr_state_t st_q;
    pwr_state_t st_d;
    logic shifting_q;
    wire force_pd = txg_q[TXG_FORCE_PD_BIT];
    wire pd_req = !pwr_q[PWR_ON_BIT] || force_pd || lost_q;
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_OFF: begin
                if (!pd_req) begin
                    st_d = ST_ON;
                end
            end
            ST_ON: begin
                if (pd_req) begin
                    st_d = shifting_q ? ST_DRAIN : ST_OFF;
                end
            end
            ST_DRAIN: begin
                if (!shifting_q) begin
                    st_d = ST_OFF;
                end
            end
            default: st_d = ST_OFF;
        endcase
    end
    wire is_on = st_q != ST_OFF;
    wire power_power_active = st_q == ST_ON;
    wire ear_sel = pwr_q[PWR_EAR_SEL_BIT];

    // ****************************************************************
    // transmit fifo and serial shifter
    // ****************************************************************
    logic [SAMPLE_WIDTH-1:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic fifo_ready;
    wire take_w = sample_valid && sample_ready;
    sample_fifo #(
        .WIDTH(SAMPLE_WIDTH),
        .DEPTH(FIFO_WORDS)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .flush(!is_on),
        .in_valid(take_w),
        .in_ready(fifo_ready),
        .in_data(sample_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );
    wire [4:0] word_bits = (fmt_q == FMT_LINEAR) ?
        5'(LINEAR_BITS) : 5'(COMPANDED_BITS);
    logic [SAMPLE_WIDTH-1:0] tx_sh_q;
    logic [4:0] tx_left_q;
    logic frame_q;
    logic out_q;
    logic oe_q;
    logic last_q;
    wire start_word = power_power_active && frame_q && bclk_rise
        && !shifting_q;
    assign fifo_pop = start_word && fifo_valid;
    wire [SAMPLE_WIDTH-1:0] word_w = fifo_valid ? fifo_data : '0;
    wire [SAMPLE_WIDTH-1:0] aligned_w = (fmt_q == FMT_LINEAR) ?
        {word_w[LINEAR_BITS-1:0], 1'b0} :
        {word_w[COMPANDED_BITS-1:0], 8'h00};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_q <= 1'b0;
            tx_sh_q <= '0;
            tx_left_q <= '0;
            shifting_q <= 1'b0;
            out_q <= 1'b0;
            oe_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            if (bclk_fall && fs_s_q[1]) begin
                frame_q <= 1'b1;
            end else if (start_word) begin
                frame_q <= 1'b0;
            end
            if (lost_q) begin
                oe_q <= 1'b0;
                shifting_q <= 1'b0;
                last_q <= 1'b0;
            end else if (start_word) begin
                out_q <= aligned_w[SAMPLE_WIDTH-1];
                oe_q <= 1'b1;
                tx_sh_q <= {aligned_w[SAMPLE_WIDTH-2:0], 1'b0};
                tx_left_q <= word_bits - 5'h1;
                shifting_q <= 1'b1;
                last_q <= word_bits == 5'h1;
            end else if (shifting_q && bclk_rise && !last_q) begin
                out_q <= tx_sh_q[SAMPLE_WIDTH-1];
                tx_sh_q <= {tx_sh_q[SAMPLE_WIDTH-2:0], 1'b0};
                tx_left_q <= tx_left_q - 5'h1;
                last_q <= tx_left_q == 5'h1;
            end else if (shifting_q && bclk_fall && last_q) begin
                oe_q <= 1'b0;
                shifting_q <= 1'b0;
                last_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // receive shifter
    // ****************************************************************
    logic [SAMPLE_WIDTH-1:0] rx_sh_q;
    logic [4:0] rx_cnt_q;
    logic rx_act_q;
    logic [SAMPLE_WIDTH-1:0] rx_q;
    logic rx_v_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_sh_q <= '0;
            rx_cnt_q <= '0;
            rx_act_q <= 1'b0;
            rx_q <= '0;
            rx_v_q <= 1'b0;
        end else begin
            rx_v_q <= 1'b0;
            if (bclk_fall && power_power_active) begin
                if (fs_s_q[1] && !rx_act_q) begin
                    rx_act_q <= 1'b1;
                    rx_sh_q <= '0;
                    rx_cnt_q <= '0;
                end else if (rx_act_q) begin
                    rx_sh_q <= {rx_sh_q[SAMPLE_WIDTH-2:0], din_s_q[1]};
                    rx_cnt_q <= rx_cnt_q + 5'h1;
                    if (rx_cnt_q == word_bits - 5'h1) begin
                        rx_act_q <= 1'b0;
                        rx_q <= {rx_sh_q[SAMPLE_WIDTH-2:0], din_s_q[1]};
                        rx_v_q <= 1'b1;
                    end
                end
            end
        end
    end

    // ****************************************************************
    // registered outputs
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_OFF;
            differential_earpiece_amp <= 1'b0;
            single_ended_earpiece_amp <= 1'b0;
            microphone_mute_select <= 1'b0;
            sample_ready <= 1'b0;
            tx_gain_mode_bit <= 1'b1;
            tx_mic2_gain_db <= '0;
            tx_pga_atten_db <= '0;
        end else begin
            st_q <= st_d;
            differential_earpiece_amp <= is_on && ear_sel;
            single_ended_earpiece_amp <= is_on && !ear_sel;
            microphone_mute_select <= pwr_q[PWR_MIC_MUTE_BIT];
            sample_ready <= fifo_ready && st_d != ST_OFF && !take_w;
            tx_gain_mode_bit <= txg_q[TXG_MODE_BIT];
            tx_mic2_gain_db <= gain_w.mic2_gain_db;
            tx_pga_atten_db <= gain_w.pga_atten_db;
        end
    end
    assign pcm_serial_out = out_q;
    assign pcm_serial_out_oe = oe_q;
    assign rx_sample = rx_q;
    assign rx_sample_valid = rx_v_q;
    assign power_register = pwr_q;
    assign transmit_gain_register = txg_q;
    assign format_q = fmt_q;
    assign powered_up = st_q[0];
    assign mclk_lost = lost_q;
endmodule : codec_power_and_tx_gain_control

// ### verilog/sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = cnt_q != (AW+1)'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rd_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (flush) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : sample_fifo
